// ==== ahp_top.sv ====
// Adaptive host port with burst timing, tone selection and irq pin.
// Assumes host pins are asynchronous; receiver inputs share CLK.
//
// Summary of operation
// - Burst mode, no call progress: 51 ms tone then 51 ms pause.
// - After the pause the transmitter ready status flag is set.
// - Call progress plus burst mode doubles both times to 102 ms.
// - Call progress mode suppresses reporting of received digits.
// - Single tone mode emits one tone from the low or high group.
// - All timing derives from a 3.579545 MHz oscillator rate.
// - At select falling edge, strobe pin low selects data strobe mode.
// - At select falling edge, read strobe high selects split strobes.
// - Address and data are latched to suit multiplexed or split buses.
// - One internal select qualifies accesses for every bus style.
// - Status updates on its own without strobe activity.
// - Select line and direction decode the four register accesses.
// - Received digit register is read only, holds the last digit.
// - Transmit code register is write only and picks the tone pair.
// - Control A bit 3 steers the next control write to control B.
// - Status register is read only and shows current state.
// - Irq pin flags digits or transmit ready, or copies call progress.
// - Control A: target, irq enable, call progress, tone output enable.
// - Control B: column/row, single/dual, test, burst enable.
// - Burst control bit is active low; one leaves timing to tone enable.
// - Tone output enable gates every transmit tone function.
// - Single tone bit set: column bit one high group, zero low group.
// - Call progress with irq enabled: pin follows the received tone.
`timescale 1ns/1ps
`default_nettype none
`include "ahp_params.svh"
module ahp_top
  import ahp_pkg::*;
#(
  parameter int unsigned BURST_TICKS    = `AHP_BURST_TICKS,
  parameter int unsigned CP_BURST_TICKS = `AHP_CP_BURST_TICKS
) (
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic       CS_N,
  input  wire logic       STROBE_PIN,
  input  wire logic       RW_PIN,
  input  wire logic       REGISTER_SELECT_LINE,
  input  wire logic [3:0] D_IN,
  output logic      [3:0] D_OUT,
  output logic            D_OE,
  input  wire logic       RX_DIGIT_VALID,
  input  wire logic [3:0] RX_CODE,
  input  wire logic       RX_DELAYED_STEER,
  input  wire logic       CP_SIGNAL,
  output logic            TONE_ON,
  output logic      [3:0] TONE_CODE,
  output logic            TONE_LOW_EN,
  output logic            TONE_HIGH_EN,
  output logic            INTERRUPT_OR_PROGRESS_PIN_OUT,
  output logic            INTERRUPT_OR_PROGRESS_PIN_OE
);
  ahp_state_type st;
  ahp_state_type next_st;
  logic [7:0]    pins;
  logic          s_cs_n;
  logic          s_stb;
  logic          s_rw;
  logic          s_rs;
  logic [3:0]    s_d;
  logic          rd_act;
  logic          wr_act;
  logic          cs_fall;
  logic          moto_now;
  logic          osc_tick;
  logic [3:0]    status;

  // Terminal count of a burst or pause; plain or call progress length.
  function automatic logic [`AHP_CNT_W-1:0] last_tick(input logic cp);
    last_tick = cp ? `AHP_CNT_W'(CP_BURST_TICKS - 1)
                   : `AHP_CNT_W'(BURST_TICKS - 1);
  endfunction

  // Host pins are asynchronous, so every one passes two flip-flops.
  ahp_sync #(
    .WIDTH       (8),
    .RESET_VALUE (`AHP_PIN_RESET)
  ) u_sync (
    .CLK    (CLK),
    .RESETN (RESETN),
    .D      ({CS_N, STROBE_PIN, RW_PIN, REGISTER_SELECT_LINE, D_IN}),
    .Q      (pins)
  );
  assign {s_cs_n, s_stb, s_rw, s_rs, s_d} = pins;

  // one internal select.
  // Strobe polarity depends on the bus style caught at select fall. The
  // style seen at the edge itself applies at once, since the strobe
  // levels of one style would otherwise read as an access in the other.
  always_comb begin
    moto_now = cs_fall ? !s_stb : st.moto;
    if (moto_now) begin
      rd_act = !s_cs_n && s_stb && s_rw;
      wr_act = !s_cs_n && s_stb && !s_rw;
    end else begin
      rd_act = !s_cs_n && !s_stb;
      wr_act = !s_cs_n && !s_rw;
    end
  end
  assign cs_fall = st.cs_prev && !s_cs_n;

  // oscillator rate tick.
  // A fractional accumulator yields the crystal rate from CLK, so no
  // second clock domain is needed.
  assign osc_tick = (st.acc + `AHP_ACC_W'(`AHP_OSC_HZ))
                    >= `AHP_ACC_W'(`AHP_CLK_HZ);

  assign status = {RX_DELAYED_STEER, st.rx_ready, st.tx_ready, st.irq};

  // Next state of the whole port.
  always_comb begin
    next_st = st;
    next_st.cs_prev = s_cs_n;
    next_st.rd_prev = rd_act;
    next_st.wr_prev = wr_act;
    if (osc_tick) begin
      next_st.acc = st.acc + `AHP_ACC_W'(`AHP_OSC_HZ)
                    - `AHP_ACC_W'(`AHP_CLK_HZ);
    end else begin
      next_st.acc = st.acc + `AHP_ACC_W'(`AHP_OSC_HZ);
    end
    // address latch at select.
    // Latching the select line at the select edge suits a multiplexed
    // bus, where it is only valid near the address phase.
    if (cs_fall) begin
      next_st.moto = !s_stb;
      next_st.addr = s_rs;
    end
    // data latch on strobe.
    // Data is tracked through the strobe and used at its trailing edge.
    if (wr_act) begin
      next_st.wdata = s_d;
    end
    if (RX_DIGIT_VALID && !st.control_a[`AHP_CRA_CALL_PROG]) begin
      next_st.rx_code = RX_CODE;
    end
    // burst bit active low.
    // Leaving burst mode drops any running burst at once.
    if (st.control_b[`AHP_CRB_BURST_N]) begin
      next_st.phase = AHP_IDLE;
      next_st.cnt = '0;
    end else if (st.phase != AHP_IDLE && osc_tick) begin
      if (st.cnt == last_tick(st.control_a[`AHP_CRA_CALL_PROG])) begin
        next_st.cnt = '0;
        if (st.phase == AHP_BURST) begin
          next_st.phase = AHP_PAUSE;
        end else begin
          next_st.phase = AHP_IDLE;
        end
      end else begin
        next_st.cnt = st.cnt + `AHP_CNT_W'(1);
      end
    end
    // register decode.
    // Write commits at the trailing edge of the write strobe.
    if (st.wr_prev && !wr_act) begin
      if (st.addr == `AHP_ADDR_DATA) begin
        next_st.tx_code = st.wdata;
        next_st.tx_ready = 1'b0;
        if (!st.control_b[`AHP_CRB_BURST_N]) begin
          next_st.phase = AHP_BURST;
          next_st.cnt = '0;
        end
      end else if (st.target_b) begin
        next_st.control_b = st.wdata;
        next_st.target_b = 1'b0;
      end else begin
        next_st.control_a = st.wdata;
        next_st.target_b = st.wdata[`AHP_CRA_TARGET];
      end
    end
    // A status read clears the data flag and the interrupt at its end.
    if (st.rd_prev && !rd_act && st.addr == `AHP_ADDR_CTRL) begin
      next_st.rx_ready = 1'b0;
      next_st.irq = 1'b0;
    end
    // Events are applied last so a set beats a clear in the same cycle.
    if (RX_DIGIT_VALID && !st.control_a[`AHP_CRA_CALL_PROG]) begin
      next_st.rx_ready = 1'b1;
      next_st.irq = 1'b1;
    end
    if (st.phase == AHP_PAUSE && next_st.phase == AHP_IDLE
        && !st.control_b[`AHP_CRB_BURST_N]) begin
      next_st.tx_ready = 1'b1;
      next_st.irq = 1'b1;
    end
    next_st.dout = (st.addr == `AHP_ADDR_CTRL) ? status : st.rx_code;
    if (st.control_a[`AHP_CRA_CALL_PROG]) begin
      next_st.pin_low = st.control_a[`AHP_CRA_IRQ_EN] && !CP_SIGNAL;
    end else if (st.control_b[`AHP_CRB_TEST]) begin
      next_st.pin_low = !RX_DELAYED_STEER;
    end else begin
      next_st.pin_low = st.control_a[`AHP_CRA_IRQ_EN] && st.irq;
    end
  end

  // Control registers clear at reset; software still initialises them.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st <= '0;
      st.cs_prev <= 1'b1;
      st.control_a <= `AHP_CR_RESET;
      st.control_b <= `AHP_CR_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Read data comes from a flop; the enable follows the read strobe.
  assign D_OUT = st.dout;
  assign D_OE = rd_act;

  assign TONE_ON = st.control_a[`AHP_CRA_TONE_OUT]
                   && (st.control_b[`AHP_CRB_BURST_N] || st.phase == AHP_BURST);
  assign TONE_CODE = st.tx_code;
  assign TONE_LOW_EN = TONE_ON && (!st.control_b[`AHP_CRB_SINGLE]
                                   || !st.control_b[`AHP_CRB_COLUMN]);
  assign TONE_HIGH_EN = TONE_ON && (!st.control_b[`AHP_CRB_SINGLE]
                                    || st.control_b[`AHP_CRB_COLUMN]);
  // Open drain: only ever pulls low.
  assign INTERRUPT_OR_PROGRESS_PIN_OUT = 1'b0;
  assign INTERRUPT_OR_PROGRESS_PIN_OE = st.pin_low;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  chk_burst_plain: assert property (
    ($past(st.phase) != st.phase && st.phase != AHP_BURST
     && !$past(st.control_b[`AHP_CRB_BURST_N])
     && !$past(st.control_a[`AHP_CRA_CALL_PROG]))
    |-> $past(st.cnt) == last_tick(1'b0))
    else $error("plain burst or pause ended at the wrong count");

  chk_burst_cp: assert property (
    ($past(st.phase) != st.phase && st.phase != AHP_BURST
     && !$past(st.control_b[`AHP_CRB_BURST_N])
     && $past(st.control_a[`AHP_CRA_CALL_PROG]))
    |-> $past(st.cnt) == last_tick(1'b1))
    else $error("call progress burst ended at the wrong count");

  chk_ready_after: assert property (
    (st.phase == AHP_PAUSE ##1 st.phase == AHP_IDLE
     && !$past(st.control_b[`AHP_CRB_BURST_N])) |-> st.tx_ready && st.irq)
    else $error("transmit ready not set after pause");

  chk_cp_no_digit: assert property (
    (st.control_a[`AHP_CRA_CALL_PROG] && !st.rx_ready) |=> !st.rx_ready)
    else $error("digit reported in call progress mode");

  chk_mode_detect: assert property (
    cs_fall |=> st.moto == !$past(s_stb))
    else $error("bus style not taken from strobe at select fall");

  chk_target_b: assert property (
    (st.wr_prev && !wr_act && st.addr && st.target_b)
    |=> !st.target_b && st.control_b == $past(st.wdata))
    else $error("control B write did not return target to A");

  chk_tone_gate: assert property (
    !st.control_a[`AHP_CRA_TONE_OUT] |-> !TONE_ON && !TONE_LOW_EN
                                   && !TONE_HIGH_EN)
    else $error("tone active with output disabled");

  chk_single_col: assert property (
    (TONE_ON && st.control_b[`AHP_CRB_SINGLE]) |->
    TONE_HIGH_EN == st.control_b[`AHP_CRB_COLUMN]
    && TONE_LOW_EN == !st.control_b[`AHP_CRB_COLUMN])
    else $error("single tone picked the wrong group");

  chk_cp_pin: assert property (
    (st.control_a[`AHP_CRA_CALL_PROG] && st.control_a[`AHP_CRA_IRQ_EN])
    ##1 $stable(st.control_a) |-> INTERRUPT_OR_PROGRESS_PIN_OE == !$past(CP_SIGNAL))
    else $error("progress pin does not follow the tone signal");

  chk_no_edge_read: assert property (
    cs_fall |-> !D_OE)
    else $error("read strobe seen active at the select edge");

  chk_addr_latch: assert property (
    cs_fall |=> st.addr == $past(s_rs))
    else $error("register select not latched at select fall");

  chk_tx_write: assert property (
    (st.wr_prev && !wr_act && st.addr == `AHP_ADDR_DATA)
    |=> TONE_CODE == $past(st.wdata) && !st.tx_ready)
    else $error("transmit code write not applied");

  chk_rx_capture: assert property (
    (RX_DIGIT_VALID && !st.control_a[`AHP_CRA_CALL_PROG])
    |=> st.rx_code == $past(RX_CODE))
    else $error("received digit not captured");

  chk_rx_hold: assert property (
    !(RX_DIGIT_VALID && !st.control_a[`AHP_CRA_CALL_PROG])
    |=> $stable(st.rx_code))
    else $error("received digit changed without a new digit");

  chk_status_read: assert property (
    st.addr == `AHP_ADDR_CTRL |=> D_OUT == $past(status))
    else $error("status read data is not the live state");

  chk_test_pin: assert property (
    (st.control_b[`AHP_CRB_TEST] && !st.control_a[`AHP_CRA_CALL_PROG])
    |=> INTERRUPT_OR_PROGRESS_PIN_OE == !$past(RX_DELAYED_STEER))
    else $error("test mode pin does not follow delayed steering");

  chk_irq_pin: assert property (
    (!st.control_b[`AHP_CRB_TEST] && !st.control_a[`AHP_CRA_CALL_PROG])
    |=> INTERRUPT_OR_PROGRESS_PIN_OE
        == $past(st.control_a[`AHP_CRA_IRQ_EN] && st.irq))
    else $error("interrupt pin does not follow the irq flag");

  cov_burst_done: cover property (st.phase == AHP_PAUSE ##1
                                  st.phase == AHP_IDLE);
  cov_write_b: cover property (st.target_b ##1 !st.target_b);
  cov_split_style: cover property (cs_fall && s_stb);
  cov_cp_pin: cover property (st.control_a[`AHP_CRA_CALL_PROG] && st.pin_low);
  cov_test_pin: cover property (st.control_b[`AHP_CRB_TEST] && st.pin_low);
endmodule
`default_nettype wire

// ==== ahp_params.svh ====
// Constants of the adaptive host port: offsets, bit positions, timings.
// Assumes inclusion by bare name from the package and the top module.
`ifndef AHP_PARAMS_SVH
`define AHP_PARAMS_SVH
// Clock and oscillator rates in hertz.
`define AHP_CLK_HZ 100000000
`define AHP_OSC_HZ 3579545
// Burst and pause length in ms, plain and in call progress mode.
`define AHP_BURST_MS 51
`define AHP_CP_BURST_MS 102
// Oscillator ticks per burst, rounded down to stay inside tolerance.
`define AHP_BURST_TICKS ((`AHP_BURST_MS * `AHP_OSC_HZ) / 1000)
`define AHP_CP_BURST_TICKS ((`AHP_CP_BURST_MS * `AHP_OSC_HZ) / 1000)
// Counter widths for the burst timer and the oscillator accumulator.
`define AHP_CNT_W 19
`define AHP_ACC_W 27
// Register select decode.
`define AHP_ADDR_DATA 1'b0
`define AHP_ADDR_CTRL 1'b1
// Control register A bit positions.
`define AHP_CRA_TONE_OUT 0
`define AHP_CRA_CALL_PROG 1
`define AHP_CRA_IRQ_EN 2
`define AHP_CRA_TARGET 3
// Control register B bit positions.
`define AHP_CRB_BURST_N 0
`define AHP_CRB_TEST 1
`define AHP_CRB_SINGLE 2
`define AHP_CRB_COLUMN 3
// Status register bit positions.
`define AHP_ST_IRQ 0
`define AHP_ST_TX_READY 1
`define AHP_ST_RX_READY 2
`define AHP_ST_STEER 3
// Reset values.
`define AHP_CR_RESET 4'h0
`define AHP_PIN_RESET 8'h80
`endif

// ==== ahp_pkg.sv ====
// Types shared by the adaptive host port modules.
// Assumes ahp_params.svh is on the include path.
`default_nettype none
`include "ahp_params.svh"
package ahp_pkg;
  typedef enum logic [1:0] {AHP_IDLE, AHP_BURST, AHP_PAUSE} ahp_phase_type;
  typedef struct packed {
    logic                    moto;
    logic                    cs_prev;
    logic                    rd_prev;
    logic                    wr_prev;
    logic                    addr;
    logic [3:0]              wdata;
    logic [3:0]              control_a;
    logic [3:0]              control_b;
    logic                    target_b;
    logic [3:0]              tx_code;
    logic [3:0]              rx_code;
    logic                    rx_ready;
    logic                    tx_ready;
    logic                    irq;
    logic                    pin_low;
    ahp_phase_type           phase;
    logic [`AHP_CNT_W-1:0]   cnt;
    logic [`AHP_ACC_W-1:0]   acc;
    logic [3:0]              dout;
  } ahp_state_type;
endpackage
`default_nettype wire

// ==== ahp_sync.sv ====
// Two flip-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level; the reset value is a constant.
`timescale 1ns/1ps
`default_nettype none
module ahp_sync #(
  parameter int              WIDTH       = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             CLK,
  input  wire logic             RESETN,
  input  wire logic [WIDTH-1:0] D,
  output logic      [WIDTH-1:0] Q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] q;
  } ahp_sync_state_type;

  ahp_sync_state_type st;
  ahp_sync_state_type next_st;

  // The first stage feeds only the second stage.
  always_comb begin
    next_st.meta = D;
    next_st.q = st.meta;
  end

  // Both stages start at the idle pin levels.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st <= {RESET_VALUE, RESET_VALUE};
    end else begin
      st <= next_st;
    end
  end

  assign Q = st.q;
endmodule
`default_nettype wire

// ==== ahp_host_model.sv ====
// Host microcontroller model that drives the adaptive host port pins.
// Assumes the bench calls its tasks one at a time, off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module ahp_host_model (
  input  wire logic       clk,
  output logic            cs_n,
  output logic            strobe,
  output logic            rw,
  output logic            rs,
  output logic      [3:0] d_in,
  input  wire logic [3:0] d_out
);
  // Every phase is held two clocks or more so the pin synchronisers see it.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Split strobe write: read strobe high at the select fall picks the style.
  task automatic wr(input logic a, input logic [3:0] v);
    strobe = 1'b1;
    rw     = 1'b1;
    rs     = a;
    cyc(2);
    cs_n = 1'b0;
    cyc(4);
    rw   = 1'b0;
    d_in = v;
    cyc(6);
    rw = 1'b1;
    cyc(4);
    cs_n = 1'b1;
    d_in = ~v; // Released data lines show the inverse, never a stale copy.
    cyc(6);
  endtask

  // Data strobe read: strobe low at the select fall picks the style.
  task automatic rd(input logic a, output logic [3:0] v);
    strobe = 1'b0;
    rw     = 1'b1;
    rs     = a;
    cyc(2);
    cs_n = 1'b0;
    cyc(4);
    strobe = 1'b1;
    cyc(8);
    v      = d_out;
    strobe = 1'b0;
    cyc(4);
    cs_n = 1'b1;
    cyc(6);
  endtask

  // Data strobe write: strobe low at the select fall, R/W low throughout.
  task automatic wr_ds(input logic a, input logic [3:0] v);
    strobe = 1'b0;
    rw     = 1'b0;
    rs     = a;
    d_in   = v;
    cyc(2);
    cs_n = 1'b0;
    cyc(4);
    strobe = 1'b1;
    cyc(6);
    strobe = 1'b0;
    cyc(4);
    cs_n = 1'b1;
    rw   = 1'b1;
    d_in = ~v;
    cyc(6);
  endtask

  // Split strobe read: read strobe high at the select fall, then low.
  task automatic rd_sp(input logic a, output logic [3:0] v);
    strobe = 1'b1;
    rw     = 1'b1;
    rs     = a;
    cyc(2);
    cs_n = 1'b0;
    cyc(4);
    strobe = 1'b0;
    cyc(8);
    v      = d_out;
    strobe = 1'b1;
    cyc(4);
    cs_n = 1'b1;
    cyc(6);
  endtask

  initial begin
    cs_n   = 1'b1;
    strobe = 1'b1;
    rw     = 1'b1;
    rs     = 1'b0;
    d_in   = 4'h0;
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the adaptive host port with a host model.
// Assumes short burst counts; expectations come from the oscillator rate.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_count++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  localparam int BT  = 20;
  localparam int CBT = 40;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       cs_n, strobe, rw, rs;
  logic [3:0] d_in, d_out, rx_code, tone_code, st, v;
  logic       d_oe, rx_valid = 1'b0, steer = 1'b0, cp_sig = 1'b1;
  logic       tone_on, low_en, high_en, pin_out, pin_oe;
  int         err_count = 0, check_count = 0, seed = 56095, n, e;
  logic [3:0] bsel [3] = '{4'h1, 4'h5, 4'hd};

  ahp_top #(.BURST_TICKS(BT), .CP_BURST_TICKS(CBT)) ahp_top_inst (
    .CLK(clk), .RESETN(resetn), .CS_N(cs_n), .STROBE_PIN(strobe),
    .RW_PIN(rw), .REGISTER_SELECT_LINE(rs), .D_IN(d_in), .D_OUT(d_out),
    .D_OE(d_oe), .RX_DIGIT_VALID(rx_valid), .RX_CODE(rx_code),
    .RX_DELAYED_STEER(steer), .CP_SIGNAL(cp_sig), .TONE_ON(tone_on),
    .TONE_CODE(tone_code), .TONE_LOW_EN(low_en), .TONE_HIGH_EN(high_en),
    .INTERRUPT_OR_PROGRESS_PIN_OUT(pin_out),
    .INTERRUPT_OR_PROGRESS_PIN_OE(pin_oe));
  ahp_host_model ahp_host_model_inst (.clk(clk), .cs_n(cs_n),
    .strobe(strobe), .rw(rw), .rs(rs), .d_in(d_in), .d_out(d_out));

  // Half period of 5 ns gives the 100 MHz clock.
  always #5 clk = ~clk;

  // Clock cycles for a count of oscillator ticks at 3.579545 MHz.
  function automatic int exp_cyc(input int t);
    return int'((longint'(t) * 100000000) / 3579545);
  endfunction
  // Length within the stated two percent, plus synchroniser slack.
  function automatic logic near(input int got, input int want);
    return (got >= want - want / 50 - 30) && (got <= want + want / 50 + 30);
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Bounded wait for tone (sel 0) or irq pin (sel 1) to reach a level.
  task automatic wait_lvl(input int sel, input logic lv, output int cnt);
    cnt = 0;
    while (((sel == 0) ? tone_on : pin_oe) !== lv && cnt < 5000) begin
      @(posedge clk);
      cnt++;
    end
    #1;
    if (cnt >= 5000) begin
      err_count++;
      give_verdict();
    end
  endtask

  task automatic pulse_rx(input logic [3:0] c);
    rx_code  = c;
    rx_valid = 1'b1;
    ahp_host_model_inst.cyc(1);
    rx_valid = 1'b0;
    ahp_host_model_inst.cyc(3);
  endtask

  initial begin
    rx_code = 4'h0;
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    ahp_host_model_inst.cyc(3);
    `CHK("reset d_oe", 1'b0, d_oe)
    `CHK("reset tone", 1'b0, tone_on)
    `CHK("reset pin", 1'b0, pin_oe)
    `CHK("reset pin out", 1'b0, pin_out)
    // Host-timed tones with burst off, in each tone group choice.
    // host-timed tones.
    for (int i = 0; i < 3; i++) begin
      ahp_host_model_inst.wr(1'b1, 4'h8);
      ahp_host_model_inst.wr_ds(1'b1, bsel[i]);
      ahp_host_model_inst.wr(1'b1, 4'h1);
      `CHK("tone on", 1'b1, tone_on)
      `CHK("low grp", ~bsel[i][2] | ~bsel[i][3], low_en)
      `CHK("high grp", ~bsel[i][2] | bsel[i][3], high_en)
      ahp_host_model_inst.wr(1'b1, 4'h0);
      `CHK("tone off", 1'b0, tone_on)
    end
    // Burst mode, first plain and then with call progress.
    ahp_host_model_inst.wr(1'b1, 4'h8);
    ahp_host_model_inst.wr(1'b1, 4'h0);
    for (int cp = 0; cp < 2; cp++) begin
      e = exp_cyc(cp ? CBT : BT);
      ahp_host_model_inst.wr(1'b1, {2'b01, cp[0], 1'b1});
      v = 4'($random(seed));
      ahp_host_model_inst.wr(1'b0, v);
      `CHK("tx code", v, tone_code)
      wait_lvl(0, 1'b0, n);
      `CHK("burst len", 1'b1, near(n + 20, e))
      if (cp == 0) begin
        wait_lvl(1, 1'b1, n);
        `CHK("pause len", 1'b1, near(n, e))
      end else begin
        `CHK("cp burst", 1'b1, near(n + 20, exp_cyc(CBT)))
        ahp_host_model_inst.cyc(e + e / 50 + 40);
      end
      ahp_host_model_inst.rd(1'b1, st);
      `CHK("tx ready", 1'b1, st[1])
    end
    // Call progress: pin copies the tone input, digits are ignored.
    for (int i = 0; i < 8; i++) begin
      cp_sig = 1'($random(seed));
      pulse_rx(4'($random(seed)));
      `CHK("cp pin", ~cp_sig, pin_oe)
    end
    ahp_host_model_inst.rd(1'b1, st);
    `CHK("cp no digit", 1'b0, st[2])
    // Digit reception with interrupt enabled in DTMF mode.
    ahp_host_model_inst.wr(1'b1, 4'h4);
    for (int i = 0; i < 4; i++) begin
      steer = 1'($random(seed));
      v = 4'($random(seed));
      pulse_rx(v);
      `CHK("digit irq", 1'b1, pin_oe)
      if (i[0]) begin
        ahp_host_model_inst.rd_sp(1'b0, st);
      end else begin
        ahp_host_model_inst.rd(1'b0, st);
      end
      `CHK("rx digit", v, st)
      ahp_host_model_inst.rd(1'b1, st);
      `CHK("rx ready", 2'b11, {st[2], st[3] == steer})
      ahp_host_model_inst.rd(1'b1, st);
      `CHK("rx cleared", 1'b0, st[2])
      `CHK("irq cleared", 1'b0, pin_oe)
    end
    // Test mode: the pin copies the delayed steering bit.
    ahp_host_model_inst.wr(1'b1, 4'hc);
    ahp_host_model_inst.wr_ds(1'b1, 4'h2);
    for (int i = 0; i < 4; i++) begin
      steer = i[0];
      ahp_host_model_inst.cyc(3);
      `CHK("test pin", ~steer, pin_oe)
    end
    give_verdict();
  end
endmodule
`default_nettype wire
